// ### hdl/channel_scan_sequencer.v
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "channel_scan_sequencer_map.vh"

module channel_scan_sequencer #(
  parameter CHANNELS = 128,
  parameter SLOTS = 8,
  parameter TENTH_CYCLES = `TENTH_CYCLES
) (
  input wire i_clock,
  input wire i_reset_n,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_write,
  input wire i_read,
  input wire [15:0] i_slot_type,
  input wire i_meas_valid,
  input wire i_meas_alarm,
  output reg [31:0] o_rdata,
  output reg o_chan_valid,
  output reg [6:0] o_chan_num,
  output reg [4:0] o_chan_type,
  output reg o_chan_ac,
  output reg o_scan_start,
  output reg o_scan_store,
  output reg o_alarm_event,
  output reg o_fault
);

  localparam ST_IDLE = 3'b001;
  localparam ST_WALK = 3'b010;
  localparam ST_WAIT = 3'b100;

  // Reset release through two flops so every flop leaves reset on the same edge.
  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_n;
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // Slot sense pins come from outside; three flops, a change counts when stages two and three agree.
  reg [15:0] slot_s1_q;
  reg [15:0] slot_s2_q;
  reg [15:0] slot_s3_q;
  reg [15:0] slot_q;
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      slot_s1_q <= 16'h0000;
      slot_s2_q <= 16'h0000;
      slot_s3_q <= 16'h0000;
      slot_q <= 16'h0000;
    end else begin
      slot_s1_q <= i_slot_type;
      slot_s2_q <= slot_s1_q;
      slot_s3_q <= slot_s2_q;
      if (slot_s2_q == slot_s3_q) begin
        slot_q <= slot_s3_q;
      end
    end
  end

  // True when the type code fits the module sensed in that slot.
  function type_fits;
    input [1:0] mod;
    input [4:0] code;
    begin
      case (mod)
        `MOD_TC: type_fits = (code >= `TYPE_TC_LO && code <= `TYPE_TC_HI) ||
          (code >= `TYPE_LVDC_LO && code <= `TYPE_LVDC_NOCHK_HI);
        `MOD_LV: type_fits = (code >= `TYPE_LVDC_LO && code <= `TYPE_LVDC_HI) ||
          (code >= `TYPE_LVAC_LO && code <= `TYPE_LVAC_HI);
        `MOD_HV: type_fits = (code >= `TYPE_HVDC_LO && code <= `TYPE_HVDC_HI) ||
          (code >= `TYPE_HVAC_LO && code <= `TYPE_HVAC_HI);
        default: type_fits = 1'b0;
      endcase
    end
  endfunction

  // AC codes mean the range is a peak-to-peak maximum.
  function is_ac;
    input [4:0] code;
    begin
      is_ac = (code >= `TYPE_LVAC_LO && code <= `TYPE_LVAC_HI) ||
        (code >= `TYPE_HVAC_LO && code <= `TYPE_HVAC_HI);
    end
  endfunction

  // Per-channel table: type code and scan membership.
  reg [4:0] type_mem [0:CHANNELS-1];
  reg [CHANNELS-1:0] in_scan_q;
  reg [CHANNELS-1:0] typed_q;

  // Range command state: a range write is applied one channel per cycle.
  reg range_busy_q;
  reg [7:0] range_cur_q;
  reg [7:0] range_last_q;
  reg [4:0] range_type_q;
  reg range_scan_q;
  reg [21:0] norm_ivl_q;
  reg [21:0] acq_ivl_q;
  reg armed_q;
  reg acquiring_q;
  reg fault_q;
  wire lock;
  wire cfg_write;
  wire rng_write;
  wire [7:0] w_first;
  wire [7:0] w_last;
  wire [4:0] w_type;
  wire [1:0] cur_mod;
  wire cur_ok;

  assign lock = armed_q | acquiring_q;
  assign cfg_write = i_write && (i_addr == `REG_CHAN_CFG);
  assign rng_write = i_write && (i_addr == `REG_CHAN_RANGE);
  assign w_first = i_wdata[`CFG_CHAN_MSB:`CFG_CHAN_LSB];
  assign w_last = rng_write ? i_wdata[`CFG_LAST_MSB:`CFG_LAST_LSB] : w_first;
  assign w_type = i_wdata[`CFG_TYPE_MSB:`CFG_TYPE_LSB];
  assign cur_mod = slot_q[2*range_cur_q[6:4] +: 2];
  // A channel must exist in the 128 space and its slot must hold a fitting module.
  assign cur_ok = (range_cur_q < CHANNELS) && type_fits(cur_mod, range_type_q);

  // Configuration engine; a set of the fault bit wins over a clear in the same cycle.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      range_busy_q <= 1'b0;
      range_cur_q <= 8'h00;
      range_last_q <= 8'h00;
      range_type_q <= 5'h00;
      range_scan_q <= 1'b0;
      in_scan_q <= {CHANNELS{1'b0}};
      typed_q <= {CHANNELS{1'b0}};
      fault_q <= 1'b0;
    end else begin
      if (i_write && i_addr == `REG_FAULT && i_wdata[`FAULT_CHAN_BIT]) begin
        fault_q <= 1'b0;
      end
      if (range_busy_q) begin
        if (cur_ok) begin
          in_scan_q[range_cur_q[6:0]] <= range_scan_q;
          typed_q[range_cur_q[6:0]] <= 1'b1;
        end else begin
          fault_q <= 1'b1;
        end
        if (range_cur_q >= range_last_q || range_cur_q == 8'hFF) begin
          range_busy_q <= 1'b0;
        end
        range_cur_q <= range_cur_q + 8'h01;
      end else if ((cfg_write || rng_write) && !lock) begin
        range_busy_q <= 1'b1;
        range_cur_q <= w_first;
        range_last_q <= w_last;
        range_type_q <= w_type;
        range_scan_q <= i_wdata[`CFG_SCAN_BIT];
      end
    end
  end

  // Type table write; a table without reset keeps it a plain memory.
  always @(posedge i_clock) begin
    if (range_busy_q && cur_ok) begin
      type_mem[range_cur_q[6:0]] <= range_type_q;
    end
  end

  // Interval registers and acquisition state; intervals saturate at 99 hours.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      norm_ivl_q <= `RESET_IVL;
      acq_ivl_q <= `RESET_IVL;
      armed_q <= 1'b0;
      acquiring_q <= 1'b0;
    end else if (i_write) begin
      if (i_addr == `REG_NORM_IVL) begin
        norm_ivl_q <= (i_wdata[21:0] > `IVL_MAX_TENTHS) ? `IVL_MAX_TENTHS : i_wdata[21:0];
      end
      if (i_addr == `REG_ACQ_IVL) begin
        acq_ivl_q <= (i_wdata[21:0] > `IVL_MAX_TENTHS) ? `IVL_MAX_TENTHS : i_wdata[21:0];
      end
      if (i_addr == `REG_CONTROL) begin
        armed_q <= i_wdata[`CTL_ARM_BIT];
        if (i_wdata[`CTL_STOP_BIT]) begin
          acquiring_q <= 1'b0;
        end else if (i_wdata[`CTL_ACQ_BIT]) begin
          acquiring_q <= 1'b1;
        end
      end
    end
  end

  // Tenth-second enable from a divider.
  reg [31:0] div_q;
  wire tenth;
  assign tenth = (div_q == TENTH_CYCLES - 1);
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 32'h00000000;
    end else if (tenth) begin
      div_q <= 32'h00000000;
    end else begin
      div_q <= div_q + 32'h00000001;
    end
  end

  // Interval timer: reloads at every scan tick with the interval of the current region.
  reg [21:0] ivl_cnt_q;
  wire [21:0] ivl_sel;
  reg scan_due_q;
  assign ivl_sel = acquiring_q ? acq_ivl_q : norm_ivl_q;
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      ivl_cnt_q <= 22'h000000;
      scan_due_q <= 1'b0;
    end else if (o_scan_start) begin
      ivl_cnt_q <= ivl_sel;
      scan_due_q <= (ivl_sel == 22'h000000);
    end else if (!scan_due_q && tenth) begin
      if (ivl_cnt_q <= 22'h000001) begin
        scan_due_q <= 1'b1;
      end
      ivl_cnt_q <= ivl_cnt_q - 22'h000001;
    end
  end

  // Next member of the scan list at or above a channel; 8'hFF means none.
  function [7:0] next_member;
    input [CHANNELS-1:0] mask;
    input [7:0] from;
    integer k;
    begin
      next_member = 8'hFF;
      for (k = CHANNELS - 1; k >= 0; k = k - 1) begin
        if (mask[k] && k >= from) begin
          next_member = k[7:0];
        end
      end
    end
  endfunction

  // Scan walker: one channel per cycle, whole list every scan, paced by the timer.
  reg [2:0] state_q;
  reg [7:0] walk_q;
  reg [CHANNELS-1:0] snap_q;
  wire [7:0] nxt;
  assign nxt = next_member(snap_q, walk_q);
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      walk_q <= 8'h00;
      snap_q <= {CHANNELS{1'b0}};
      o_scan_start <= 1'b0;
      o_chan_valid <= 1'b0;
      o_chan_num <= 7'h00;
      o_chan_type <= 5'h00;
      o_chan_ac <= 1'b0;
      o_scan_store <= 1'b0;
    end else begin
      o_scan_start <= 1'b0;
      o_chan_valid <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (|in_scan_q && !range_busy_q) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (scan_due_q && !o_scan_start && |in_scan_q && !range_busy_q) begin
            snap_q <= in_scan_q;
            walk_q <= 8'h00;
            o_scan_start <= 1'b1;
            o_scan_store <= acquiring_q;
            state_q <= ST_WALK;
          end else if (~|in_scan_q) begin
            state_q <= ST_IDLE;
          end
        end
        ST_WALK: begin
          if (nxt == 8'hFF) begin
            state_q <= ST_WAIT;
          end else begin
            o_chan_valid <= 1'b1;
            o_chan_num <= nxt[6:0];
            o_chan_type <= type_mem[nxt[6:0]];
            o_chan_ac <= is_ac(type_mem[nxt[6:0]]);
            walk_q <= nxt + 8'h01;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Alarm event pulse and fault output.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_alarm_event <= 1'b0;
      o_fault <= 1'b0;
    end else begin
      o_alarm_event <= i_meas_valid & i_meas_alarm;
      o_fault <= fault_q;
    end
  end

  // The type table has no reset, so entries never written read back as zero, not as unknown contents.
  wire [4:0] chan_type_rd;
  assign chan_type_rd = typed_q[i_wdata[6:0]] ? type_mem[i_wdata[6:0]] : 5'h00;

  // Read port: data one cycle after the strobe, zero elsewhere and for unmapped addresses.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 32'h00000000;
    end else if (i_read) begin
      case (i_addr)
        `REG_NORM_IVL: o_rdata <= {10'h000, norm_ivl_q};
        `REG_ACQ_IVL: o_rdata <= {10'h000, acq_ivl_q};
        `REG_CONTROL: o_rdata <= {30'h00000000, acquiring_q, armed_q};
        `REG_STATUS: o_rdata <= {27'h0000000, range_busy_q, state_q, lock};
        `REG_FAULT: o_rdata <= {31'h00000000, fault_q};
        `REG_SLOTS: o_rdata <= {16'h0000, slot_q};
        `REG_CHAN_READ: o_rdata <= {26'h0000000, in_scan_q[i_wdata[6:0]], chan_type_rd};
        default: o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

endmodule

// ### hdl/channel_scan_sequencer_map.vh
`ifndef CHANNEL_SCAN_SEQUENCER_MAP_VH
`define CHANNEL_SCAN_SEQUENCER_MAP_VH
// Register offsets (byte addresses on the plain register port, one 32-bit register every 4).
`define REG_CHAN_CFG 8'h00
`define REG_CHAN_RANGE 8'h04
`define REG_NORM_IVL 8'h08
`define REG_ACQ_IVL 8'h0C
`define REG_CONTROL 8'h10
`define REG_STATUS 8'h14
`define REG_FAULT 8'h18
`define REG_SLOTS 8'h1C
`define REG_CHAN_READ 8'h20
// Field positions of the channel configuration word.
`define CFG_TYPE_LSB 0
`define CFG_TYPE_MSB 4
`define CFG_SCAN_BIT 5
`define CFG_CHAN_LSB 8
`define CFG_CHAN_MSB 15
`define CFG_LAST_LSB 16
`define CFG_LAST_MSB 23
// Control bits.
`define CTL_ARM_BIT 0
`define CTL_ACQ_BIT 1
`define CTL_STOP_BIT 2
// Fault origin bits.
`define FAULT_CHAN_BIT 0
// Module type codes reported by a slot.
`define MOD_EMPTY 2'h0
`define MOD_TC 2'h1
`define MOD_LV 2'h2
`define MOD_HV 2'h3
// Type code ranges.
`define TYPE_TC_LO 5'h01
`define TYPE_TC_HI 5'h09
`define TYPE_LVDC_LO 5'h0B
`define TYPE_LVDC_HI 5'h0E
`define TYPE_LVDC_NOCHK_LO 5'h0F
`define TYPE_LVDC_NOCHK_HI 5'h12
`define TYPE_HVDC_LO 5'h14
`define TYPE_HVDC_HI 5'h16
`define TYPE_LVAC_LO 5'h17
`define TYPE_LVAC_HI 5'h1A
`define TYPE_HVAC_LO 5'h1C
`define TYPE_HVAC_HI 5'h1E
// Interval timing.
`define TENTH_NS 100000000
`define CLOCK_NS 20
`define TENTH_CYCLES (`TENTH_NS / `CLOCK_NS)
`define IVL_MAX_TENTHS 22'h3661E0
`define RESET_IVL 22'h000000
`endif

// ### verification/channel_scan_sequencer_monitor.sv
`timescale 1ns/1ps
`include "channel_scan_sequencer_map.vh"
module channel_scan_sequencer_monitor (
  input wire i_clock,
  input wire i_reset_n,
  input wire i_read,
  input wire [31:0] o_rdata,
  input wire i_meas_valid,
  input wire i_meas_alarm,
  input wire o_alarm_event,
  input wire o_chan_valid,
  input wire [6:0] o_chan_num,
  input wire [4:0] o_chan_type,
  input wire o_chan_ac,
  input wire o_scan_start,
  input wire o_scan_store
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // A scan announcement must be followed at once by its first member.
  sequence walk_opens;
    o_scan_start ##1 o_chan_valid;
  endsequence
  // The AC flag must match the code ranges of both voltage modules.
  wire ac_code = (o_chan_type >= `TYPE_LVAC_LO && o_chan_type <= `TYPE_LVAC_HI) ||
    (o_chan_type >= `TYPE_HVAC_LO && o_chan_type <= `TYPE_HVAC_HI);
  a_alarm_follows: assert property (i_meas_valid && i_meas_alarm |=> o_alarm_event)
    else $error("alarm event missing");
  a_alarm_cause: assert property (o_alarm_event |-> $past(i_meas_valid && i_meas_alarm))
    else $error("alarm event without cause");
  a_rdata_quiet: assert property (!$past(i_read) |-> o_rdata == 32'h00000000)
    else $error("read data outside answer cycle");
  a_chan_ascend: assert property (o_chan_valid && $past(o_chan_valid) |-> o_chan_num > $past(o_chan_num))
    else $error("scan order not ascending");
  a_walk_opens: assert property (o_scan_start |-> walk_opens)
    else $error("scan start without walk");
  a_ac_flag: assert property (o_chan_valid |-> o_chan_ac == ac_code)
    else $error("ac flag wrong");
  a_typed_only: assert property (o_chan_valid |-> o_chan_type != 5'h00)
    else $error("unconfigured channel scanned");
  a_store_steady: assert property (o_chan_valid && $past(o_chan_valid) |-> $stable(o_scan_store))
    else $error("store flag changed mid scan");
endmodule

// ### verification/meas_front_model.sv
`timescale 1ns/1ps
module meas_front_model (
  input wire i_clock,
  input wire i_reset_n,
  input wire i_chan_valid,
  input wire [6:0] i_chan_num,
  input wire [6:0] i_alarm_chan,
  output reg o_meas_valid,
  output reg o_meas_alarm
);
  // Answers each presented channel one cycle later; the alarm line toggles when no result is valid,
  // so a design that ignores the valid qualifier shows stray events.
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_meas_valid <= 1'b0;
      o_meas_alarm <= 1'b0;
    end else begin
      o_meas_valid <= i_chan_valid;
      o_meas_alarm <= i_chan_valid ? (i_chan_num == i_alarm_chan) : ~o_meas_alarm;
    end
  end
endmodule

// ### verification/test_channel_scan_sequencer.sv
`timescale 1ns/1ps
`include "channel_scan_sequencer_map.vh"
module test_channel_scan_sequencer;
  reg i_clock = 0;
  reg i_reset_n = 0;
  reg [7:0] i_addr = 0;
  reg [31:0] i_wdata = 0;
  reg i_write = 0;
  reg i_read = 0;
  reg [15:0] i_slot_type = 16'h0039;
  wire i_meas_valid, i_meas_alarm, o_chan_valid, o_chan_ac, o_scan_start, o_scan_store, o_alarm_event, o_fault;
  wire [31:0] o_rdata;
  wire [6:0] o_chan_num;
  wire [4:0] o_chan_type;
  integer err_total = 0;
  integer n_checks = 0;
  integer k, g, m;
  localparam integer TB_TENTH = 4;
  reg [5:0] cfg [0:127];
  reg [31:0] v;
  channel_scan_sequencer #(.TENTH_CYCLES(TB_TENTH)) DUT (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .i_slot_type(i_slot_type),
    .i_meas_valid(i_meas_valid), .i_meas_alarm(i_meas_alarm), .o_rdata(o_rdata), .o_chan_valid(o_chan_valid),
    .o_chan_num(o_chan_num), .o_chan_type(o_chan_type), .o_chan_ac(o_chan_ac), .o_scan_start(o_scan_start),
    .o_scan_store(o_scan_store), .o_alarm_event(o_alarm_event), .o_fault(o_fault));
  meas_front_model pm (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_chan_valid(o_chan_valid),
    .i_chan_num(o_chan_num), .i_alarm_chan(7'h14), .o_meas_valid(i_meas_valid), .o_meas_alarm(i_meas_alarm));
  // Free-running 50 MHz clock.
  initial begin
    forever #10 i_clock = ~i_clock;
  end
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] s);
    n_checks = n_checks + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge i_clock);
    i_addr <= a; i_wdata <= d; i_write <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe, so it is sampled just after that edge.
  task rd(input [7:0] a, input [31:0] d);
    @(posedge i_clock);
    i_addr <= a; i_wdata <= d; i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 v = o_rdata;
  endtask
  task idle;
    for (int i = 0; i < 300; i++) begin
      rd(`REG_STATUS, 0);
      if (v[4] === 1'b0) return;
    end
    err_total = err_total + 1;
    finish_test;
  endtask
  function automatic bit fits(input [1:0] m, input [4:0] c);
    case (m)
      `MOD_TC: fits = (c >= 1 && c <= 9) || (c >= 11 && c <= 18);
      `MOD_LV: fits = (c >= 11 && c <= 14) || (c >= 23 && c <= 26);
      `MOD_HV: fits = (c >= 20 && c <= 22) || (c >= 28 && c <= 30);
      default: fits = 0;
    endcase
  endfunction
  function automatic bit ac_of(input [4:0] c);
    ac_of = (c >= 23 && c <= 26) || (c >= 28 && c <= 30);
  endfunction
  // One channel command, then fault flag and stored word against the model.
  task cfg_one(input [7:0] ch, input [5:0] tc);
    bit ok;
    wr(`REG_CHAN_CFG, {16'h0000, ch, 2'b00, tc});
    idle;
    ok = ch < 128 && fits(i_slot_type[2 * ch[6:4] +: 2], tc[4:0]);
    if (ok) cfg[ch[6:0]] = tc;
    rd(`REG_FAULT, 0);
    chk("fault", {31'h0, !ok}, {31'h0, v[0]});
    chk("fault pin", {31'h0, !ok}, {31'h0, o_fault});
    wr(`REG_FAULT, 32'h00000001);
    rd(`REG_CHAN_READ, {24'h0, ch});
    if (ch < 128) chk("chan word", {26'h0, cfg[ch[6:0]]}, {26'h0, v[5:0]});
  endtask
  // Always step past the current negedge first, so a start pulse already seen is never taken twice.
  task wait_start;
    for (g = 0; g < 3000; g++) begin
      @(negedge i_clock);
      if (o_scan_start === 1'b1) break;
    end
    if (g >= 3000) begin
      err_total = err_total + 1;
      finish_test;
    end
  endtask
  // Called right after wait_start; g ends as the start-to-start distance minus one.
  task gap;
    wait_start;
  endtask
  // The alarm event of a member appears two members later: model answer, then the event flop.
  task scan_check;
    integer p1, p2;
    p1 = -1;
    p2 = -1;
    wait_start;
    for (k = 0; k < 128; k++) if (cfg[k][5]) begin
      @(negedge i_clock);
      chk("scan valid", 1, {31'h0, o_chan_valid});
      chk("scan chan", k, {25'h0, o_chan_num});
      chk("scan type", cfg[k][4:0], {27'h0, o_chan_type});
      chk("scan ac", {31'h0, ac_of(cfg[k][4:0])}, {31'h0, o_chan_ac});
      chk("alarm event", {31'h0, p2 == 20}, {31'h0, o_alarm_event});
      p2 = p1;
      p1 = k;
    end
  endtask
  // Main sequence.
  initial begin
    void'($urandom(32'h335794b1));
    for (k = 0; k < 128; k++) cfg[k] = 0;
    repeat (2) @(posedge i_clock);
    i_reset_n <= 1'b1;
    repeat (8) @(posedge i_clock);
    rd(`REG_STATUS, 0);
    chk("idle state", 32'h00000002, v);
    rd(`REG_SLOTS, 0);
    chk("slot types", 32'h00000039, v);
    g = $urandom_range(32'h003661E0, 1);
    wr(`REG_NORM_IVL, g);
    rd(`REG_NORM_IVL, 0);
    chk("normal ivl", g, v);
    wr(`REG_ACQ_IVL, 32'h003FFFFF);
    rd(`REG_ACQ_IVL, 0);
    chk("acq ivl sat", {10'h000, `IVL_MAX_TENTHS}, v);
    wr(`REG_NORM_IVL, 0);
    wr(`REG_ACQ_IVL, 0);
    $display("interval test done");
    for (k = 0; k < 8; k++) cfg_one($urandom_range(63, 0), $urandom_range(63, 0));
    cfg_one(8'd40, 6'h3C);
    cfg_one(8'd41, 6'h36);
    cfg_one(8'd42, 6'h1F);
    cfg_one(8'd20, 6'h2B);
    cfg_one(8'd21, 6'h3A);
    cfg_one(8'd20, 6'h01);
    cfg_one(8'd60, 6'h21);
    cfg_one(8'd200, 6'h21);
    cfg_one(8'd5, 6'h2B);
    cfg_one(8'd3, 6'h21);
    wr(`REG_CHAN_RANGE, {8'h00, 8'd12, 8'd8, 8'h22});
    idle;
    for (k = 8; k <= 12; k++) cfg[k] = 6'h22;
    rd(`REG_CHAN_READ, 32'd12);
    chk("range word", 32'h22, {26'h0, v[5:0]});
    scan_check;
    scan_check;
    m = 0;
    for (k = 0; k < 128; k++) m = m + cfg[k][5];
    // Fast mode: start, one cycle per member, one cycle back to wait, then the next start.
    wait_start;
    gap;
    chk("fast pacing", m + 1, g);
    $display("config and scan test done");
    // The tenth divider runs free, so the first tenth after a reload lands one to four cycles later.
    wr(`REG_NORM_IVL, 8);
    wait_start;
    gap;
    chk("normal pacing", 1, {31'h0, g >= TB_TENTH * 7 + 2 && g <= TB_TENTH * 8 + 1});
    wr(`REG_CONTROL, 1);
    wr(`REG_CHAN_CFG, 32'h00000921);
    rd(`REG_CHAN_READ, 32'd9);
    chk("locked word", {26'h0, cfg[9]}, {26'h0, v[5:0]});
    rd(`REG_NORM_IVL, 0);
    chk("armed ivl", 8, v);
    wr(`REG_ACQ_IVL, 6);
    wr(`REG_CONTROL, 3);
    wait_start;
    gap;
    chk("acq pacing", 1, {31'h0, g >= TB_TENTH * 5 + 2 && g <= TB_TENTH * 6 + 1});
    @(negedge i_clock);
    chk("store on", 1, {31'h0, o_scan_store});
    wr(`REG_CONTROL, 4);
    wait_start;
    gap;
    chk("post-stop pacing", 1, {31'h0, g >= TB_TENTH * 7 + 2 && g <= TB_TENTH * 8 + 1});
    @(negedge i_clock);
    chk("store off", 0, {31'h0, o_scan_store});
    $display("acquisition test done");
    finish_test;
  end
endmodule
bind channel_scan_sequencer channel_scan_sequencer_monitor mon (.i_clock(i_clock), .i_reset_n(i_reset_n),
  .i_read(i_read), .o_rdata(o_rdata), .i_meas_valid(i_meas_valid), .i_meas_alarm(i_meas_alarm),
  .o_alarm_event(o_alarm_event), .o_chan_valid(o_chan_valid), .o_chan_num(o_chan_num),
  .o_chan_type(o_chan_type), .o_chan_ac(o_chan_ac), .o_scan_start(o_scan_start), .o_scan_store(o_scan_store));
